/* File: tb/rutsel_host_model.sv */
// host model driving the three-wire serial link
`timescale 1ns/1ps
module rutsel_host_model
(
  output logic sck,
  output logic sdata,
  output logic sl
);
  initial
  begin
    sck = 1'b0;
    sdata = 1'b0;
    sl = 1'b1;
  end
  // one 40-bit frame, lsb first, 80 ns link clock, sdata flipped once after sl rises
  task automatic send(input logic [11:0] a, input logic [27:0] d);
    logic [39:0] f;
    if (a >= 12'h060)
      d[27:16] = 12'h000;
    if ((a >= 12'h068) && (a <= 12'h072))
      d = 28'h0000000;
    f = {d, a};
    sl = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      sdata = f[i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 sl = 1'b1;
    sdata = ~sdata;
    #120;
  endtask
endmodule // rutsel_host_model

/* File: tb/rutsel_props.sv */
// checker for the update timing select bank
`timescale 1ns/1ps
module rutsel_props
(
  input wire        clk,
  input wire        rst,
  input wire        sl,
  input wire        vsync_in,
  input wire [5:0]  work_rd_idx,
  input wire [63:0] pending,
  input wire [15:0] ctrl_rd_data
);
  reg seen_reg;
  always @(posedge clk)
    seen_reg <= !rst && (seen_reg || !sl);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property dflt(i, v);
    !seen_reg && work_rd_idx[2:0] == i |-> ctrl_rd_data == v;
  endproperty
  fe_sl_a: assert property (dflt(0, 16'h1803)) else $error("bad default");
  fe_vs_a: assert property (dflt(1, 16'he7fc)) else $error("bad default");
  misc_sl_a: assert property (dflt(2, 16'hf8fd)) else $error("bad default");
  misc_vs_a: assert property (dflt(3, 16'h0702)) else $error("bad default");
  sync_sl_a: assert property (dflt(4, 16'hfff9)) else $error("bad default");
  sync_vs_a: assert property (dflt(5, 16'h0006)) else $error("bad default");
  tc_sl_a: assert property (dflt(6, 16'hffff)) else $error("bad default");
  tc_vs_a: assert property (dflt(7, 16'h0000)) else $error("bad default");
  pend_set_a: assert property (|(pending & ~$past(pending)) |-> $past(sl, 3))
    else $error("pending set without load");
  pend_clr_a: assert property (|($past(pending) & ~pending) |-> $past(vsync_in, 3))
    else $error("pending cleared without vsync");
  cover property (|pending);
  cover property (seen_reg && ctrl_rd_data == 16'h0001);
  cover property ($fell(vsync_in));
endmodule // rutsel_props
bind rutsel_update_bank rutsel_props u_rutsel_props (.clk, .rst, .sl, .vsync_in, .work_rd_idx,
  .pending, .ctrl_rd_data);

/* File: tb/test_register_update_timing_select.sv */
// testbench for the update timing select bank
`timescale 1ns/1ps
module test_register_update_timing_select;
  logic        clk;
  logic        rst;
  logic        sck;
  logic        sdata;
  logic        sl;
  logic        vsync_in;
  logic [5:0]  work_rd_idx;
  logic [27:0] work_rd_data;
  logic [63:0] pending;
  logic [15:0] ctrl_rd_data;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  rutsel_update_bank u_rutsel_update_bank (.clk, .rst, .sck, .sdata, .sl, .vsync_in,
    .work_rd_idx, .work_rd_data, .pending, .ctrl_rd_data);
  rutsel_host_model u_rutsel_host_model (.sck, .sdata, .sl);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk({27'h0, g}, {27'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [27:0] d);
    @(posedge clk);
    #1 u_rutsel_host_model.send(a, d);
  endtask
  task automatic rd(input logic [5:0] i, output logic [27:0] d);
    @(posedge clk);
    #1 work_rd_idx = i;
    repeat (2) @(posedge clk);
    #1 d = work_rd_data;
  endtask
  task automatic vsync_pulse();
    @(posedge clk);
    #1 vsync_in = 1'b1;
    repeat (10) @(posedge clk);
    #1 vsync_in = 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic t_defaults();
    logic [27:0] d;
    rd(6'h00, d);
    chk({12'h000, ctrl_rd_data}, 28'h0001803);
    rd(6'h01, d);
    chk({12'h000, ctrl_rd_data}, 28'h000e7fc);
    rd(6'h02, d);
    chk({12'h000, ctrl_rd_data}, 28'h000f8fd);
    rd(6'h03, d);
    chk({12'h000, ctrl_rd_data}, 28'h0000702);
    rd(6'h04, d);
    chk({12'h000, ctrl_rd_data}, 28'h000fff9);
    rd(6'h05, d);
    chk({12'h000, ctrl_rd_data}, 28'h0000006);
    rd(6'h06, d);
    chk({12'h000, ctrl_rd_data}, 28'h000ffff);
    rd(6'h07, d);
    chk({12'h000, ctrl_rd_data}, 28'h0000000);
    chk(d, 28'h0000000);
  endtask
  task automatic t_strobe();
    logic [27:0] d;
    logic [5:0]  a [3] = '{6'h00, 6'h10, 6'h37};
    foreach (a[k])
    begin
      wr({6'h00, a[k]}, {22'h2a5a5a, a[k]});
      rd(a[k], d);
      chk(d, {22'h2a5a5a, a[k]});
      chk_bit(pending[a[k]], 1'b0);
    end
  endtask
  task automatic t_vsync();
    logic [27:0] d;
    logic [5:0]  a [3] = '{6'h02, 6'h11, 6'h21};
    foreach (a[k])
    begin
      wr({6'h00, a[k]}, {22'h15a5a5, a[k]});
      rd(a[k], d);
      chk(d, 28'h0000000);
      chk_bit(pending[a[k]], 1'b1);
    end
    vsync_pulse();
    foreach (a[k])
    begin
      rd(a[k], d);
      chk(d, {22'h15a5a5, a[k]});
    end
  endtask
  task automatic t_ctrl();
    logic [27:0] d;
    wr(12'h067, 28'h0000001);
    wr(12'h066, 28'h000fffe);
    rd(6'h07, d);
    chk({12'h000, ctrl_rd_data}, 28'h0000001);
    rd(6'h06, d);
    chk({12'h000, ctrl_rd_data}, 28'h000fffe);
    wr(12'h030, 28'h0c0ffee);
    rd(6'h30, d);
    chk(d, 28'h0000000);
    chk_bit(pending[6'h30], 1'b1);
    vsync_pulse();
    rd(6'h30, d);
    chk(d, 28'h0c0ffee);
    chk_bit(pending[6'h30], 1'b0);
  endtask
  task automatic t_none();
    logic [27:0] d;
    wr(12'h023, 28'h0123456);
    rd(6'h23, d);
    chk(d, 28'h0000000);
    chk_bit(pending[6'h23], 1'b0);
    vsync_pulse();
    rd(6'h23, d);
    chk(d, 28'h0000000);
  endtask
  initial
  begin
    rst = 1'b1;
    vsync_in = 1'b0;
    work_rd_idx = 6'h00;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    t_defaults();
    t_strobe();
    t_vsync();
    t_ctrl();
    t_none();
    end_of_test();
  end
endmodule // test_register_update_timing_select

/* File: verilog/rutsel_consts.vh */
// constants for the register update timing select bank
`ifndef RUTSEL_CONSTS_VH
`define RUTSEL_CONSTS_VH

// serial frame layout, address first, lsb first
`define RUTSEL_ADDR_BITS      12
`define RUTSEL_DATA_BITS      28
`define RUTSEL_FRAME_BITS     6'd40
`define RUTSEL_ADDR_LSB       0
`define RUTSEL_DATA_LSB       12
`define RUTSEL_ENA_BITS       16

// update control register offsets
`define RUTSEL_FE_STROBE_OFS  12'h060
`define RUTSEL_FE_VSYNC_OFS   12'h061
`define RUTSEL_MISC_STROBE_OFS 12'h062
`define RUTSEL_MISC_VSYNC_OFS 12'h063
`define RUTSEL_SYNC_STROBE_OFS 12'h064
`define RUTSEL_SYNC_VSYNC_OFS 12'h065
`define RUTSEL_TC_STROBE_OFS  12'h066
`define RUTSEL_TC_VSYNC_OFS   12'h067
`define RUTSEL_RSVD_FIRST_OFS 12'h068
`define RUTSEL_RSVD_LAST_OFS  12'h072

// reset values of the update control registers
`define RUTSEL_FE_STROBE_RST  16'h1803
`define RUTSEL_FE_VSYNC_RST   16'he7fc
`define RUTSEL_MISC_STROBE_RST 16'hf8fd
`define RUTSEL_MISC_VSYNC_RST 16'h0702
`define RUTSEL_SYNC_STROBE_RST 16'hfff9
`define RUTSEL_SYNC_VSYNC_RST 16'h0006
`define RUTSEL_TC_STROBE_RST  16'hffff
`define RUTSEL_TC_VSYNC_RST   16'h0000

// staged register space and groups
`define RUTSEL_STAGE_DEPTH    64
`define RUTSEL_STAGE_IDX_BITS 6
`define RUTSEL_GRP_FE         2'h0
`define RUTSEL_GRP_MISC       2'h1
`define RUTSEL_GRP_SYNC       2'h2
`define RUTSEL_GRP_TC         2'h3
`define RUTSEL_SYNC_LAST_IDX  4'h2
`define RUTSEL_TC_LAST_IDX    4'h7

`endif

/* File: verilog/rutsel_update_bank.v */
// update timing select bank with staged and working register copies
`timescale 1ns/1ps
`include "rutsel_consts.vh"

module rutsel_update_bank
(
  input  wire        clk,
  input  wire        rst,
  input  wire        sck,
  input  wire        sdata,
  input  wire        sl,
  input  wire        vsync_in,
  input  wire [5:0]  work_rd_idx,
  output reg  [27:0] work_rd_data,
  output wire [63:0] pending,
  output wire [15:0] ctrl_rd_data
);

  // three-stage samplers for sck, sdata, sl, vsync_in (bit order 3..0)
  reg  [3:0]  samp1_reg;
  reg  [3:0]  samp2_reg;
  reg  [3:0]  samp3_reg;
  reg  [3:0]  filt_reg;
  wire [3:0]  agree;
  wire [3:0]  rise;

  reg  [39:0] shift_reg;
  reg  [5:0]  count_reg;
  reg  [15:0] ena_reg [0:7];
  reg  [27:0] stage_reg [0:63];
  reg  [27:0] work_reg [0:63];
  reg  [63:0] pend_reg;

  wire [11:0] frame_addr;
  wire [27:0] frame_data;
  wire        commit;
  wire        vs_evt;
  wire [1:0]  frame_sel;
  integer     i;
  integer     k;

  // returns {strobe_en, vsync_en} for one staged register index
  function [1:0] sel_for;
    input [5:0]  idx;
    input [15:0] fe_s;
    input [15:0] fe_v;
    input [15:0] mi_s;
    input [15:0] mi_v;
    input [15:0] sy_s;
    input [15:0] sy_v;
    input [15:0] tc_s;
    input [15:0] tc_v;
    reg   [3:0]  b;
    begin
      b = idx[3:0];
      case (idx[5:4])
        `RUTSEL_GRP_FE:
          sel_for = {fe_s[b], fe_v[b]};
        `RUTSEL_GRP_MISC:
          sel_for = {mi_s[b], mi_v[b]};
        `RUTSEL_GRP_SYNC:
          sel_for = (b <= `RUTSEL_SYNC_LAST_IDX) ? {sy_s[b], sy_v[b]} : 2'h0;
        `RUTSEL_GRP_TC:
          sel_for = (b <= `RUTSEL_TC_LAST_IDX) ? {tc_s[b], tc_v[b]} : 2'h0;
        default:
          sel_for = 2'h0;
      endcase
    end
  endfunction

  // a pin change counts once the second and third stages agree
  assign agree = ~(samp2_reg ^ samp3_reg);
  assign rise  = agree & samp3_reg & ~filt_reg;

  always @(posedge clk)
  begin
    if (rst)
    begin
      // every stage starts at the filter's high state, so no false rise follows reset
      samp1_reg <= 4'hf;
      samp2_reg <= 4'hf;
      samp3_reg <= 4'hf;
      filt_reg  <= 4'hf;
    end
    else
    begin
      samp1_reg <= {sck, sdata, sl, vsync_in};
      samp2_reg <= samp1_reg;
      samp3_reg <= samp2_reg;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (agree[i])
          filt_reg[i] <= samp3_reg[i];
      end
    end
  end

  assign vs_evt     = rise[0];
  assign commit     = rise[1] && (count_reg == `RUTSEL_FRAME_BITS);
  assign frame_addr = shift_reg[`RUTSEL_ADDR_LSB +: `RUTSEL_ADDR_BITS];
  assign frame_data = shift_reg[`RUTSEL_DATA_LSB +: `RUTSEL_DATA_BITS];
  assign frame_sel  = sel_for(frame_addr[5:0], ena_reg[0], ena_reg[1], ena_reg[2],
                              ena_reg[3], ena_reg[4], ena_reg[5], ena_reg[6], ena_reg[7]);

  // serial shifter: lsb first, bits taken on sck rise while sl is low
  always @(posedge clk)
  begin
    if (rst)
    begin
      shift_reg <= 40'h0;
      count_reg <= 6'h0;
    end
    else if (filt_reg[1])
    begin
      count_reg <= 6'h0;
    end
    else if (rise[3] && (count_reg != `RUTSEL_FRAME_BITS))
    begin
      shift_reg <= {filt_reg[2], shift_reg[39:1]};
      count_reg <= count_reg + 6'h1;
    end
  end

  // update control registers, themselves updated on the load strobe
  always @(posedge clk)
  begin
    if (rst)
    begin
      ena_reg[0] <= `RUTSEL_FE_STROBE_RST;
      ena_reg[1] <= `RUTSEL_FE_VSYNC_RST;
      ena_reg[2] <= `RUTSEL_MISC_STROBE_RST;
      ena_reg[3] <= `RUTSEL_MISC_VSYNC_RST;
      ena_reg[4] <= `RUTSEL_SYNC_STROBE_RST;
      ena_reg[5] <= `RUTSEL_SYNC_VSYNC_RST;
      ena_reg[6] <= `RUTSEL_TC_STROBE_RST;
      ena_reg[7] <= `RUTSEL_TC_VSYNC_RST;
    end
    else if (commit && (frame_addr >= `RUTSEL_FE_STROBE_OFS)
             && (frame_addr <= `RUTSEL_TC_VSYNC_OFS))
    begin
      // bits 27:16 are dropped, the host keeps them zero
      // reserved offsets 0x68..0x72 fall outside the range and are ignored
      ena_reg[frame_addr[2:0]] <= frame_data[15:0];
    end
  end

  // staging, working copies and pending flags
  always @(posedge clk)
  begin
    if (rst)
    begin
      pend_reg <= 64'h0;
      for (k = 0; k < `RUTSEL_STAGE_DEPTH; k = k + 1)
      begin
        stage_reg[k] <= 28'h0;
        work_reg[k]  <= 28'h0;
      end
    end
    else
    begin
      // vertical sync moves every pending, vsync-enabled staged value
      if (vs_evt)
      begin
        for (k = 0; k < `RUTSEL_STAGE_DEPTH; k = k + 1)
        begin
          if (pend_reg[k] && sel_for(k[5:0], ena_reg[0], ena_reg[1], ena_reg[2],
                                     ena_reg[3], ena_reg[4], ena_reg[5], ena_reg[6],
                                     ena_reg[7]) != 2'h2 &&
              sel_for(k[5:0], ena_reg[0], ena_reg[1], ena_reg[2], ena_reg[3],
                      ena_reg[4], ena_reg[5], ena_reg[6], ena_reg[7]) != 2'h0)
          begin
            work_reg[k] <= stage_reg[k];
            pend_reg[k] <= 1'b0;
          end
        end
      end
      // a new write beats a same-cycle vsync transfer of its own slot
      if (commit && (frame_addr < 12'h040))
      begin
        stage_reg[frame_addr[5:0]] <= frame_data;
        if (frame_sel[1])
        begin
          work_reg[frame_addr[5:0]] <= frame_data;
          pend_reg[frame_addr[5:0]] <= 1'b0;
        end
        else if (frame_sel[0])
        begin
          pend_reg[frame_addr[5:0]] <= 1'b1;
        end
        else
        begin
          pend_reg[frame_addr[5:0]] <= 1'b0;
        end
      end
    end
  end

  // registered read of the working copy
  always @(posedge clk)
  begin
    if (rst)
      work_rd_data <= 28'h0;
    else
      work_rd_data <= work_reg[work_rd_idx];
  end

  assign pending      = pend_reg;
  assign ctrl_rd_data = ena_reg[work_rd_idx[2:0]];

endmodule // rutsel_update_bank
